// ---- hdl/rcp_calendar_power.sv ----
// Purpose: Always-on calendar counter with match wake and core power monitor.
// Assumes: APB master on pclk; crystal and power pins are asynchronous.
// Notes: The calendar is advanced by carries, not recomputed from the count.
module rcp_calendar_power
#(
    parameter bit USE_INITIAL_STATE = 1'b0
)
(
    input wire logic pclk, // System clock, 100 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic xtal_clk, // Crystal clock pin, 32.768 kHz.
    input wire logic power_up_request_n, // Wake request pin, active low.
    input wire logic regulator_power_down, // Power-down input, high = off.
    input wire logic regulator_initial_state, // Start-up supply state.
    output logic core_supply_enable, // Regulator enable for the core.
    output logic core_logic_valid, // Core is functional.
    output logic core_power_up, // Inverse of the wake request pin.
    output logic counter_match_wake, // Counter equals match register.
    output logic irq // Level interrupt, high while unmasked event set.
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic xtal_s;
    logic pu_n_s;
    logic pd_s;
    logic init_s;

    rcp_sync3 #(.RESET_VALUE(1'b0)) xtal_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(xtal_clk),
        .sync_out(xtal_s)
    );

    // The request idles high, so reset to the idle level avoids a wake.
    rcp_sync3 #(.RESET_VALUE(1'b1)) pu_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(power_up_request_n),
        .sync_out(pu_n_s)
    );

    rcp_sync3 #(.RESET_VALUE(1'b0)) pd_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(regulator_power_down),
        .sync_out(pd_s)
    );

    rcp_sync3 #(.RESET_VALUE(1'b0)) init_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(regulator_initial_state),
        .sync_out(init_s)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] month_days(input logic [3:0] m,
                                              input logic [6:0] y);
        logic [4:0] d;
        d = 5'h1f;
        case (m)
            4'h4, 4'h6, 4'h9, 4'hb: d = 5'h1e;
            4'h2: d = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: d = 5'h1f;
        endcase
        return d;
    endfunction

    rcp_pkg::rcp_state_type s;
    rcp_pkg::rcp_state_type next_s;

    logic xtal_rise;
    logic count_step;
    logic sec_tick;
    logic wr;
    logic setup;
    logic [rcp_pkg::IRQ_WIDTH-1:0] events;
    logic [rcp_pkg::IRQ_WIDTH-1:0] w1c;

    assign xtal_rise = xtal_s && !s.xtal_prev;
    assign count_step = xtal_rise && s.run
                        && (s.presc == rcp_pkg::PRESCALE_LAST);
    assign sec_tick = count_step && (s.count[7:0] == rcp_pkg::SECOND_LAST);
    assign wr = psel && penable && pwrite && s.pready;
    assign setup = psel && !penable;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        events = '0;
        w1c = '0;
        next_s.xtal_prev = xtal_s;

        // Prescaler and counter keep going in every power state.
        if (xtal_rise && s.run)
        begin
            next_s.presc = s.presc + 7'h01;
        end
        if (count_step)
        begin
            next_s.count = s.count + 40'h1;
        end

        // Seconds carry out of counter bit 7 and ripple up.
        if (sec_tick)
        begin
            events[rcp_pkg::IRQ_SECOND_BIT] = 1'b1;
            next_s.sec = s.sec + 6'h01;
            if (s.sec == rcp_pkg::MINUTE_LAST)
            begin
                next_s.sec = 6'h00;
                next_s.min = s.min + 6'h01;
                if (s.min == rcp_pkg::MINUTE_LAST)
                begin
                    next_s.min = 6'h00;
                    next_s.hour = s.hour + 5'h01;
                    if (s.hour == rcp_pkg::HOUR_LAST)
                    begin
                        next_s.hour = 5'h00;
                        next_s.wday = (s.wday == rcp_pkg::WDAY_LAST)
                                      ? 3'h0 : s.wday + 3'h1;
                        next_s.mday = s.mday + 5'h01;
                        if (s.mday >= month_days(s.mon, s.year))
                        begin
                            next_s.mday = 5'h01;
                            next_s.mon = s.mon + 4'h1;
                            if (s.mon == rcp_pkg::MONTH_LAST)
                            begin
                                next_s.mon = 4'h1;
                                next_s.year = (s.year == rcp_pkg::YEAR_LAST)
                                              ? 7'h00 : s.year + 7'h01;
                            end
                        end
                    end
                end
            end
        end

        // Match flag is a registered equality of count and match.
        next_s.match_hit = (s.count == s.match);
        if (next_s.match_hit && !s.match_hit)
        begin
            events[rcp_pkg::IRQ_MATCH_BIT] = 1'b1;
        end

        // Power monitor.
        case (s.pwr)
            rcp_pkg::pwr_start:
            begin
                // Wait for the synchronisers to settle before sampling.
                next_s.settle = s.settle + 3'h1;
                if (s.settle == rcp_pkg::SETTLE_LAST)
                begin
                    if (USE_INITIAL_STATE && !init_s)
                    begin
                        next_s.pwr = rcp_pkg::pwr_off;
                    end
                    else
                    begin
                        next_s.pwr = rcp_pkg::pwr_on;
                    end
                end
            end
            rcp_pkg::pwr_off:
            begin
                if (!pd_s && (!pu_n_s || (s.wake_en && s.match_hit)))
                begin
                    next_s.pwr = rcp_pkg::pwr_on;
                    events[rcp_pkg::IRQ_WAKE_BIT] = 1'b1;
                end
            end
            rcp_pkg::pwr_on:
            begin
                if (pd_s)
                begin
                    next_s.pwr = rcp_pkg::pwr_off;
                    events[rcp_pkg::IRQ_SLEEP_BIT] = 1'b1;
                end
            end
            default:
            begin
                next_s.pwr = rcp_pkg::pwr_start;
            end
        endcase
        next_s.supply_en = (next_s.pwr == rcp_pkg::pwr_on);
        // Valid lags the supply by a cycle and drops with it.
        next_s.valid = s.supply_en && (next_s.pwr == rcp_pkg::pwr_on);
        next_s.core_power_up = !pu_n_s;

        // Bus writes override the running values of the same cycle.
        if (wr)
        begin
            case (paddr)
                rcp_pkg::CTRL_OFS:
                begin
                    next_s.run = pwdata[rcp_pkg::CTRL_RUN_BIT];
                    next_s.wake_en = pwdata[rcp_pkg::CTRL_WAKE_EN_BIT];
                end
                rcp_pkg::COUNT_LO_OFS: next_s.count[31:0] = pwdata;
                rcp_pkg::COUNT_HI_OFS: next_s.count[39:32] = pwdata[7:0];
                rcp_pkg::MATCH_LO_OFS: next_s.match[31:0] = pwdata;
                rcp_pkg::MATCH_HI_OFS: next_s.match[39:32] = pwdata[7:0];
                rcp_pkg::TIME_OFS:
                begin
                    next_s.sec = pwdata[5:0];
                    next_s.min = pwdata[13:8];
                    next_s.hour = pwdata[20:16];
                    next_s.wday = pwdata[26:24];
                end
                rcp_pkg::DATE_OFS:
                begin
                    next_s.mday = pwdata[4:0];
                    next_s.mon = pwdata[11:8];
                    next_s.year = pwdata[22:16];
                end
                rcp_pkg::IRQ_STATUS_OFS: w1c = pwdata[3:0];
                rcp_pkg::IRQ_MASK_OFS: next_s.irq_mask = pwdata[3:0];
                default:
                begin
                end
            endcase
        end
        // A new event in the clearing cycle stays set.
        next_s.irq_st = (s.irq_st & ~w1c) | events;
        next_s.irq = |(next_s.irq_st & next_s.irq_mask);

        // Zero-wait slave: data and ready are prepared in the setup cycle.
        next_s.pready = setup;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0;
        if (setup)
        begin
            case (paddr)
                rcp_pkg::CTRL_OFS:
                    next_s.prdata = {30'h0, s.wake_en, s.run};
                rcp_pkg::STATUS_OFS:
                    next_s.prdata = {28'h0, !pu_n_s, s.valid,
                                     s.supply_en, s.match_hit};
                rcp_pkg::COUNT_LO_OFS: next_s.prdata = s.count[31:0];
                rcp_pkg::COUNT_HI_OFS: next_s.prdata = {24'h0, s.count[39:32]};
                rcp_pkg::MATCH_LO_OFS: next_s.prdata = s.match[31:0];
                rcp_pkg::MATCH_HI_OFS: next_s.prdata = {24'h0, s.match[39:32]};
                rcp_pkg::TIME_OFS:
                    next_s.prdata = {5'h0, s.wday, 3'h0, s.hour,
                                     2'h0, s.min, 2'h0, s.sec};
                rcp_pkg::DATE_OFS:
                    next_s.prdata = {9'h0, s.year, 4'h0, s.mon,
                                     3'h0, s.mday};
                rcp_pkg::IRQ_STATUS_OFS: next_s.prdata = {28'h0, s.irq_st};
                rcp_pkg::IRQ_MASK_OFS: next_s.prdata = {28'h0, s.irq_mask};
                default: next_s.pslverr = 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.pwr <= rcp_pkg::pwr_start;
            s.run <= rcp_pkg::RUN_RESET;
            s.wake_en <= rcp_pkg::WAKE_EN_RESET;
            s.irq_mask <= rcp_pkg::IRQ_MASK_RESET;
            s.mday <= rcp_pkg::MDAY_RESET;
            s.mon <= rcp_pkg::MONTH_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign core_supply_enable = s.supply_en;
    assign core_logic_valid = s.valid;
    assign core_power_up = s.core_power_up;
    assign counter_match_wake = s.match_hit;
    assign irq = s.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_count;
    logic wr_date;
    assign wr_count = wr && (paddr == rcp_pkg::COUNT_LO_OFS
                             || paddr == rcp_pkg::COUNT_HI_OFS);
    assign wr_date = wr && (paddr == rcp_pkg::DATE_OFS
                            || paddr == rcp_pkg::TIME_OFS);

    pu_inverse_a: assert property (##1 core_power_up == !$past(pu_n_s))
        else $error("core power-up is not the inverse of the request");

    pd_off_a: assert property (
        s.pwr == rcp_pkg::pwr_on && pd_s |=> !core_supply_enable
                                             ##1 !core_logic_valid)
        else $error("power-down did not remove the core supply");

    wake_on_a: assert property (
        s.pwr == rcp_pkg::pwr_off && !pd_s && !pu_n_s
        |=> core_supply_enable ##1 core_logic_valid)
        else $error("power-up request did not wake the core");

    valid_supply_a: assert property (
        core_logic_valid |-> core_supply_enable && $past(core_supply_enable))
        else $error("core valid without a settled supply");

    count_off_a: assert property (
        count_step && !wr_count && s.pwr == rcp_pkg::pwr_off
        |=> s.count == $past(s.count) + 40'h1)
        else $error("counter stopped while the core was off");

    prescale_a: assert property (
        xtal_rise && s.run && s.presc != rcp_pkg::PRESCALE_LAST && !wr_count
        |=> $stable(s.count) && s.presc == $past(s.presc) + 7'h01)
        else $error("counter moved before 128 crystal periods");

    sec_carry_a: assert property (
        sec_tick && !wr_date && s.sec != rcp_pkg::MINUTE_LAST
        |=> s.sec == $past(s.sec) + 6'h01 && $stable(s.min))
        else $error("second did not follow the counter carry");

    feb_end_a: assert property (
        sec_tick && !wr_date && s.mon == 4'h2 && s.mday == 5'h1c
        && s.year[1:0] != 2'h0 && s.hour == rcp_pkg::HOUR_LAST
        && s.min == rcp_pkg::MINUTE_LAST && s.sec == rcp_pkg::MINUTE_LAST
        |=> s.mday == 5'h01 && s.mon == 4'h3)
        else $error("February did not end at day 28 in a common year");

    match_wake_a: assert property (
        s.count == s.match |=> counter_match_wake)
        else $error("match flag missing while count equals match");

    init_state_a: assert property (
        s.pwr == rcp_pkg::pwr_start && s.settle == rcp_pkg::SETTLE_LAST
        && USE_INITIAL_STATE && !init_s |=> !core_supply_enable [*2])
        else $error("supply came up although start-up state was off");

endmodule

// ---- hdl/rcp_pkg.sv ----
// Purpose: Constants and types for the calendar counter and power monitor.
// Assumes: pclk at 100 MHz, crystal at 32.768 kHz sampled as a pin.
// Notes: Register offsets are byte addresses on a 32-bit APB slave.
//
// Overview of operation
// - Calendar fields advance from the seconds carried out of the counter.
// - Day of month wraps at each month's true length, February leap-aware.
// - Counter is 40 bits, with a 40-bit match register and a match flag.
// - Crystal is divided by 128 before the counter; bit 7 has 1 s period.
// - Core supply follows match, flag and pins; counter runs while core off.
// - Power-up request pin low, with power-down at zero, wakes the core by enabling its supply.
// - Power-down input at one switches the core supply off into standby.
// - Optional initial-state input picks supply on or off at power-up.
// - Match-wake signal shows counter equals match and may wake the core.
// - Core-valid output is one only while the core is functional.
// - Core power-up output is the inverse of the power-up request pin.
package rcp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COUNT_LO_OFS = 8'h08;
    localparam logic [7:0] COUNT_HI_OFS = 8'h0c;
    localparam logic [7:0] MATCH_LO_OFS = 8'h10;
    localparam logic [7:0] MATCH_HI_OFS = 8'h14;
    localparam logic [7:0] TIME_OFS = 8'h18;
    localparam logic [7:0] DATE_OFS = 8'h1c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WAKE_EN_BIT = 1;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_SECOND_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int IRQ_SLEEP_BIT = 3;
    localparam int IRQ_WIDTH = 4;
    localparam int COUNT_WIDTH = 40;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RUN_RESET = 1'b1;
    localparam logic WAKE_EN_RESET = 1'b0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [4:0] MDAY_RESET = 5'h01;
    localparam logic [3:0] MONTH_RESET = 4'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int XTAL_FREQ_HZ = 32768;
    localparam int PRESCALE_DIV = 128;
    localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE_DIV - 1);
    localparam logic [7:0] SECOND_LAST = 8'(XTAL_FREQ_HZ / PRESCALE_DIV - 1);
    localparam logic [2:0] SETTLE_LAST = 3'h4;
    localparam logic [5:0] MINUTE_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [2:0] WDAY_LAST = 3'h6;
    localparam logic [3:0] MONTH_LAST = 4'hc;
    localparam logic [6:0] YEAR_LAST = 7'h63;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        pwr_start = 3'b001,
        pwr_off = 3'b010,
        pwr_on = 3'b100
    } rcp_pwr_type;

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
    } rcp_sync_type;

    typedef struct packed
    {
        rcp_pwr_type pwr;
        logic [2:0] settle;
        logic xtal_prev;
        logic [6:0] presc;
        logic [COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0] match;
        logic match_hit;
        logic run;
        logic wake_en;
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hour;
        logic [2:0] wday;
        logic [4:0] mday;
        logic [3:0] mon;
        logic [6:0] year;
        logic [IRQ_WIDTH-1:0] irq_st;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic core_power_up;
        logic supply_en;
        logic valid;
    } rcp_state_type;

endpackage

// ---- hdl/rcp_sync3.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: async_in may change at any time relative to pclk.
// Notes: The filtered level only moves when stages two and three agree.
module rcp_sync3
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic async_in, // Pin level from outside the domain.
    output logic sync_out // Filtered level.
);

    rcp_pkg::rcp_sync_type s;
    rcp_pkg::rcp_sync_type next_s;

    always_comb
    begin
        next_s = s;
        next_s.s1 = async_in;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3)
        begin
            next_s.stable = s.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule

// ---- verif/rcp_far_side.sv ----
// Purpose: Far-side model: crystal pin, wake switch and power-down switch.
// Assumes: The bench calls the tasks; pins change just after pclk edges.
// Notes: The crystal toggles only on demand, so edge counts stay exact.
module rcp_far_side
(
    input wire logic pclk, // System clock.
    output logic xtal_clk, // Crystal pin.
    output logic power_up_request_n, // Wake switch, active low.
    output logic regulator_power_down, // Power-down switch, high = off.
    output logic regulator_initial_state // Start-up supply state pin.
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        xtal_clk = 1'b0;
        power_up_request_n = 1'b1;
        regulator_power_down = 1'b0;
        // Held low: the copy that honours the pin must start with the
        // supply off, the copy that ignores it must still come up.
        regulator_initial_state = 1'b0;
    end

    // ----------------------------------------------------------------
    // Switches and crystal
    // ----------------------------------------------------------------
    task automatic set_switch(input logic up_n, input logic down);
        @(posedge pclk);
        power_up_request_n <= up_n;
        regulator_power_down <= down;
    endtask

    // Ten cycles per half period keeps each level well past the filter.
    task automatic run_xtal(input int n);
        repeat (n)
        begin
            repeat (10) @(posedge pclk);
            xtal_clk <= 1'b1;
            repeat (10) @(posedge pclk);
            xtal_clk <= 1'b0;
        end
    endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the calendar counter and power monitor.
// Assumes: APB answers after one access cycle; pins settle in 8 cycles.
// Notes: Each second is made from a count low byte of ff and 128 edges.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, xtal, pup_n, pdown, init_st, err;
    logic supply, valid, core_up, wake, irq, supply_off;
    logic [15:0] lfsr_q = 16'h0017;
    logic [31:0] dates [4] = '{32'h0001021c, 32'h0004021c, 32'h00630c1f,
        32'h0007041e};
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    rcp_calendar_power dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_clk(xtal),
        .power_up_request_n(pup_n), .regulator_power_down(pdown),
        .regulator_initial_state(init_st), .core_supply_enable(supply),
        .core_logic_valid(valid), .core_power_up(core_up),
        .counter_match_wake(wake), .irq(irq));
    // A second copy honours the initial-state pin, which the far side
    // holds low, so it must stay off after start-up.
    rcp_calendar_power #(.USE_INITIAL_STATE(1'b1)) dut_off (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .xtal_clk(xtal), .power_up_request_n(pup_n),
        .regulator_power_down(pdown), .regulator_initial_state(init_st),
        .core_supply_enable(supply_off), .core_logic_valid(),
        .core_power_up(), .counter_match_wake(), .irq());
    rcp_far_side far (.pclk(pclk), .xtal_clk(xtal),
        .power_up_request_n(pup_n), .regulator_power_down(pdown),
        .regulator_initial_state(init_st));

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [4:0] mlen(input logic [3:0] m,
        input logic [6:0] y);
        case (m)
            4'h2: return (y[1:0] == 2'b00) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
            default: return 5'h1f;
        endcase
    endfunction

    function automatic logic [31:0] next_date(input logic [31:0] d);
        logic [4:0] md;
        logic [3:0] mo;
        logic [6:0] yr;
        md = d[4:0] + 5'h01;
        mo = d[11:8];
        yr = d[22:16];
        if (d[4:0] >= mlen(mo, yr))
        begin
            md = 5'h01;
            yr = (mo != 4'hc) ? yr : (yr == 7'h63) ? 7'h00 : yr + 7'h01;
            mo = (mo == 4'hc) ? 4'h1 : mo + 4'h1;
        end
        return {9'h000, yr, 4'h0, mo, 3'h0, md};
    endfunction

    // ----------------------------------------------------------------
    // Checks, bus cycles and the closing report
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The request stands until pready is seen high at a rising edge; the
    // answer is taken at that edge and only then is the request released.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic one_second();
        apb(1'b1, rcp_pkg::COUNT_LO_OFS, 32'h000000ff);
        far.run_xtal(128);
        repeat (8) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (16) @(posedge pclk);
        check({wake, supply, valid, supply_off}, 32'he);
        apb(1'b0, rcp_pkg::DATE_OFS, 32'h0);
        check(rd, 32'h00000101);
        apb(1'b0, 8'h28, 32'h0);
        check({rd[30:0], err}, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            far.set_switch(lfsr_q[0], 1'b0);
            repeat (8) @(posedge pclk);
            check(core_up, !lfsr_q[0]);
        end
        far.set_switch(1'b1, 1'b1);
        apb(1'b1, rcp_pkg::IRQ_MASK_OFS, 32'h0000000c);
        repeat (8) @(posedge pclk);
        check({supply, valid, irq}, 32'h1);
        apb(1'b1, rcp_pkg::IRQ_STATUS_OFS, 32'h0000000f);
        @(posedge pclk);
        check(irq, 32'h0);
        far.set_switch(1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        check({supply, valid, irq}, 32'h7);
        far.set_switch(1'b1, 1'b1);
        apb(1'b1, rcp_pkg::IRQ_STATUS_OFS, 32'h0000000f);
        lfsr_q = lfsr(lfsr_q);
        apb(1'b1, rcp_pkg::MATCH_LO_OFS, {lfsr_q, ~lfsr_q});
        apb(1'b0, rcp_pkg::MATCH_LO_OFS, 32'h0);
        check(rd, {lfsr_q, ~lfsr_q});
        apb(1'b1, rcp_pkg::MATCH_LO_OFS, 32'h00000180);
        one_second();
        apb(1'b0, rcp_pkg::COUNT_LO_OFS, 32'h0);
        check(rd, 32'h00000100);
        apb(1'b0, rcp_pkg::TIME_OFS, 32'h0);
        check(rd[5:0], 32'h1);
        apb(1'b1, rcp_pkg::CTRL_OFS, 32'h00000003);
        far.set_switch(1'b1, 1'b0);
        repeat (8) @(posedge pclk);
        check({wake, supply}, 32'h0);
        apb(1'b1, rcp_pkg::COUNT_LO_OFS, 32'h0000017f);
        far.run_xtal(128);
        repeat (8) @(posedge pclk);
        check({wake, supply, valid}, 32'h7);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, rcp_pkg::TIME_OFS, 32'h06173b3b);
            apb(1'b1, rcp_pkg::DATE_OFS, dates[i]);
            one_second();
            apb(1'b0, rcp_pkg::TIME_OFS, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, rcp_pkg::DATE_OFS, 32'h0);
            check(rd, next_date(dates[i]));
        end
        close_out();
    end
endmodule
